// >>> design/acs_regs.vh
`ifndef ACS_REGS_VH
`define ACS_REGS_VH
// Register byte offsets
`define ACS_OFF_CTRL 12'h000
`define ACS_OFF_CHAN 12'h004
`define ACS_OFF_STAT 12'h008
`define ACS_OFF_IRQ 12'h00c
`define ACS_OFF_MASK 12'h010
`define ACS_OFF_FIFO 12'h014
// Control fields
`define ACS_CTRL_CKSEL_LO 0
`define ACS_CTRL_CKSEL_HI 1
`define ACS_CTRL_MON 2
`define ACS_CTRL_CONT 3
`define ACS_CTRL_FCLR 4
`define ACS_CTRL_RESET 5'h00
// Clock modes
`define ACS_MODE_REG 2'b00
`define ACS_MODE_PULSE 2'b01
`define ACS_MODE_RSVD 2'b10
`define ACS_MODE_EXT 2'b11
// Channels: bit 0 internal temp, bit 1 external temp, others voltage
`define ACS_NCH 11
`define ACS_CH_TEMP_MASK 11'h003
// Timing, ns, and cycles at 25 ns
`define ACS_CLK_NS 25
`define ACS_T_TRIG_SHORT_NS 20
`define ACS_T_TRIG_LONG_NS 1500
`define ACS_T_TRIG_REF_NS 50000
`define ACS_T_REF_UP_NS 45000
`define ACS_T_SENS_UP_NS 5000
`define ACS_T_TEMP_CONV_NS 30000
`define ACS_T_VEXT_NS 3500
`define ACS_T_VINT_NS 5600
// Cycle counts sized to the 12-bit counters; minimum lows rounded up
`define ACS_C_TRIG_SHORT 12'd1
`define ACS_C_TRIG_LONG 12'd60
`define ACS_C_TRIG_REF 12'd2000
`define ACS_C_REF_UP 12'd1800
`define ACS_C_SENS_UP 12'd200
`define ACS_C_TEMP_CONV 12'd1200
`define ACS_C_VEXT 12'd140
`define ACS_C_VINT 12'd224
// Interrupt status bits
`define ACS_IRQ_DONE 0
`define ACS_IRQ_OVF 1
`define ACS_FIFO_DEPTH 5'd16
`endif

// >>> design/acs_sequencer.v
// Function
// - Mode 00: register write starts full scan
// - Reset selects clock mode 00
// - Monitor on: busy, scan, store, drop busy
// - Mode 01: one trigger low scans all
// - Mode 11: one pulse, one channel
// - Temperature needs short trigger, internally timed
// - First temperature 80us, later 30us
// - External reference voltage: result 3.5us later
// - First internal reference voltage: 50us trigger
// - Later internal reference voltage: 5.6us
// - Leaving mode 00 finishes scan first
// - Leaving 01 before trigger: idle at once
// - Leaving 01 mid-sequence finishes the whole scan
// - Leaving 11: idle, or finish first
// - Continuous bit alone repeats the scan in modes 00 and 01; mode 11 rearms and waits for each pulse
`include "acs_regs.vh"
`default_nettype none
module acs_sequencer (
  input wire clk_sys,
  input wire rst_n,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire conv_trigger_pin,
  input wire ext_ref_sel,
  input wire [11:0] adc_result,
  output reg busy,
  output reg adc_power,
  output reg adc_sample,
  output reg irq
);
  localparam [5:0] S_IDLE = 6'b000001;
  localparam [5:0] S_ARM = 6'b000010;
  localparam [5:0] S_WARM = 6'b000100;
  localparam [5:0] S_CONV = 6'b001000;
  localparam [5:0] S_NEXT = 6'b010000;
  localparam [5:0] S_HOLD = 6'b100000;

  reg [4:0] ctrl;
  reg [10:0] chan;
  reg [1:0] irq_stat;
  reg [1:0] irq_mask;
  reg [5:0] state;
  reg [1:0] run_mode;
  reg [10:0] pend;
  reg [3:0] cur_ch;
  reg [11:0] cnt;
  reg [11:0] low_cnt;
  reg trig_s1;
  reg trig_s2;
  reg trig_prev;
  reg ref_up;
  reg sens_up;
  reg [15:0] fifo_data [0:`ACS_FIFO_DEPTH-1];
  reg [3:0] wr_ptr;
  reg [3:0] rd_ptr;
  reg [4:0] fifo_cnt;
  reg ap_valid;
  reg ap_write;
  reg [11:0] ap_addr;
  reg start_req;
  wire [1:0] mode = ctrl[`ACS_CTRL_CKSEL_HI:`ACS_CTRL_CKSEL_LO];
  wire trig_low = ~trig_s2;
  wire trig_rise = trig_s2 & ~trig_prev;
  wire is_temp = (cur_ch < 4'd2);
  wire store = (state == S_CONV) && (cnt == 12'h000);
  wire fifo_pop = ap_valid && !ap_write && (ap_addr == `ACS_OFF_FIFO) && (fifo_cnt != 5'd0);
  wire fifo_push = store && (fifo_cnt != `ACS_FIFO_DEPTH);
  wire ovf = store && (fifo_cnt == `ACS_FIFO_DEPTH);
  wire done_evt;
  wire [3:0] first_ch;
  integer k;
  reg [3:0] pick;
  always @* begin
    pick = 4'd0;
    for (k = `ACS_NCH - 1; k >= 0; k = k - 1) begin
      if (pend[k]) pick = k[3:0];
    end
  end
  assign first_ch = pick;

  // Synchroniser: second stage only feeds logic
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      trig_s1 <= 1'b1;
      trig_s2 <= 1'b1;
      trig_prev <= 1'b1;
      low_cnt <= 12'h000;
    end else begin
      trig_s1 <= conv_trigger_pin;
      trig_s2 <= trig_s1;
      trig_prev <= trig_s2;
      if (trig_low) begin
        if (low_cnt != 12'hfff) low_cnt <= low_cnt + 12'h001;
      end else begin
        low_cnt <= 12'h000;
      end
    end
  end

  // Minimum low time depends on the channel kind in mode 11
  reg [11:0] need_low;
  always @* begin
    need_low = `ACS_C_TRIG_SHORT;
    if (run_mode == `ACS_MODE_EXT && !is_temp) begin
      if (!ext_ref_sel && !ref_up) need_low = `ACS_C_TRIG_REF;
      else need_low = `ACS_C_TRIG_LONG;
    end
  end
  // Qualified pulse is acted on at its rising edge, once
  wire trig_ok = trig_rise && (low_cnt >= need_low) && !busy;

  // Conversion time per channel
  reg [11:0] conv_len;
  reg [11:0] warm_len;
  always @* begin
    warm_len = 12'h001;
    if (is_temp) begin
      conv_len = `ACS_C_TEMP_CONV;
      if (!ref_up) warm_len = `ACS_C_REF_UP + `ACS_C_SENS_UP;
      else if (!sens_up) warm_len = `ACS_C_SENS_UP;
    end else if (ext_ref_sel) begin
      conv_len = `ACS_C_VEXT;
    end else if (!ref_up) begin
      conv_len = `ACS_C_VEXT;
    end else begin
      conv_len = `ACS_C_VINT;
    end
  end

  // Mode 11 closes its series in the hold step, the others at the scan step
  assign done_evt = ((state == S_NEXT) || (state == S_HOLD)) && (pend == 11'h000) &&
                    !ctrl[`ACS_CTRL_CONT];

  // Per status bit: a read clears, but an event in that same cycle still sets
  wire [1:0] irq_evt = {ovf, done_evt};
  wire irq_rd_clr = ap_valid && !ap_write && (ap_addr == `ACS_OFF_IRQ);
  wire [1:0] next_irq_stat;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_irq
      assign next_irq_stat[gi] = irq_evt[gi] | (irq_stat[gi] & ~irq_rd_clr);
    end
  endgenerate

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_IDLE;
      run_mode <= `ACS_MODE_REG;
      pend <= 11'h000;
      cur_ch <= 4'd0;
      cnt <= 12'h000;
      busy <= 1'b0;
      adc_power <= 1'b0;
      adc_sample <= 1'b0;
      ref_up <= 1'b0;
      sens_up <= 1'b0;
    end else begin
      case (state)
        S_IDLE: begin
          busy <= 1'b0;
          adc_power <= 1'b0;
          adc_sample <= 1'b0;
          run_mode <= mode;
          if (chan != 11'h000) begin
            if (mode == `ACS_MODE_REG && start_req) begin
              pend <= chan;
              state <= S_NEXT;
              busy <= ctrl[`ACS_CTRL_MON];
              adc_power <= 1'b1;
            end else if ((mode == `ACS_MODE_PULSE || mode == `ACS_MODE_EXT) && start_req) begin
              pend <= chan;
              state <= S_ARM;
            end
          end
        end
        S_ARM: begin
          // Waiting on trigger: mode change drops out at once
          cur_ch <= first_ch;
          if (mode != run_mode) begin
            state <= S_IDLE;
            adc_power <= 1'b0;
            busy <= 1'b0;
          end else if (trig_ok) begin
            // One pulse runs whole scan in 01, one channel in 11
            state <= S_NEXT;
            busy <= 1'b1;
            adc_power <= 1'b1;
          end
        end
        S_NEXT: begin
          if (pend != 11'h000) begin
            cur_ch <= first_ch;
            pend[first_ch] <= 1'b0;
            state <= S_WARM;
            cnt <= 12'h000;
            adc_sample <= 1'b1;
          end else if (ctrl[`ACS_CTRL_CONT] && mode == run_mode && chan != 11'h000) begin
            pend <= chan;
            if (run_mode == `ACS_MODE_EXT) state <= S_ARM;
          end else begin
            state <= S_IDLE;
            busy <= 1'b0;
            adc_power <= 1'b0;
          end
        end
        S_WARM: begin
          cnt <= cnt + 12'h001;
          if (cnt + 12'h001 >= warm_len) begin
            if (is_temp) begin
              ref_up <= 1'b1;
              sens_up <= 1'b1;
            end else if (!ext_ref_sel) begin
              ref_up <= 1'b1;
            end
            cnt <= conv_len - 12'h001;
            state <= S_CONV;
            adc_sample <= 1'b0;
          end
        end
        S_CONV: begin
          // Busy stays high across a mode change until this ends
          if (cnt != 12'h000) begin
            cnt <= cnt - 12'h001;
          end else if (run_mode == `ACS_MODE_EXT) begin
            state <= S_HOLD;
          end else begin
            state <= S_NEXT;
          end
        end
        S_HOLD: begin
          busy <= 1'b0;
          if (mode != run_mode) begin
            state <= S_IDLE;
            adc_power <= 1'b0;
          end else if (pend != 11'h000) begin
            state <= S_ARM;
          end else if (ctrl[`ACS_CTRL_CONT] && chan != 11'h000) begin
            // Continuous in mode 11 rearms and waits for the next pulse
            pend <= chan;
            state <= S_ARM;
          end else begin
            state <= S_IDLE;
            adc_power <= 1'b0;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // AHB-Lite slave, zero wait states
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr <= 12'h000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
    end else begin
      ap_valid <= hsel && htrans[1] && hready;
      ap_write <= hwrite;
      ap_addr <= haddr[11:0];
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
      if (hsel && htrans[1] && hready && !hwrite) begin
        case (haddr[11:0])
          `ACS_OFF_CTRL: hrdata <= {27'h0, ctrl};
          `ACS_OFF_CHAN: hrdata <= {21'h0, chan};
          `ACS_OFF_STAT: hrdata <= {22'h0, fifo_cnt, state != S_IDLE, adc_power, busy,
                                   run_mode};
          `ACS_OFF_IRQ: hrdata <= {30'h0, irq_stat};
          `ACS_OFF_MASK: hrdata <= {30'h0, irq_mask};
          `ACS_OFF_FIFO: hrdata <= (fifo_cnt != 5'd0) ? {16'h0, fifo_data[rd_ptr]} : 32'h0;
          default: hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `ACS_CTRL_RESET;
      chan <= 11'h000;
      irq_mask <= 2'b00;
      irq_stat <= 2'b00;
      start_req <= 1'b0;
      irq <= 1'b0;
    end else begin
      if (state != S_IDLE) start_req <= 1'b0;
      ctrl[`ACS_CTRL_FCLR] <= 1'b0;
      if (ap_valid && ap_write) begin
        case (ap_addr)
          `ACS_OFF_CTRL: ctrl <= hwdata[4:0];
          `ACS_OFF_CHAN: begin
            chan <= hwdata[10:0];
            start_req <= 1'b1;
          end
          `ACS_OFF_MASK: irq_mask <= hwdata[1:0];
          default: ;
        endcase
      end
      irq_stat <= next_irq_stat;
      irq <= |(next_irq_stat & irq_mask);
    end
  end

  // Result FIFO: channel number above 12-bit result
  always @(posedge clk_sys) begin
    if (fifo_push) fifo_data[wr_ptr] <= {cur_ch, adc_result};
  end
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= 4'd0;
      rd_ptr <= 4'd0;
      fifo_cnt <= 5'd0;
    end else if (ctrl[`ACS_CTRL_FCLR]) begin
      wr_ptr <= 4'd0;
      rd_ptr <= 4'd0;
      fifo_cnt <= 5'd0;
    end else begin
      if (fifo_push) wr_ptr <= wr_ptr + 4'd1;
      if (fifo_pop) rd_ptr <= rd_ptr + 4'd1;
      fifo_cnt <= fifo_cnt + {4'd0, fifo_push} - {4'd0, fifo_pop};
    end
  end
endmodule // acs_sequencer
`default_nettype wire

// >>> verification/acs_host_model.sv
`default_nettype none
module acs_host_model (
  input wire logic clk_sys,
  output logic conv_trigger_pin,
  output logic [11:0] adc_result
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    conv_trigger_pin = 1'b1;
    adc_result = 12'h5a3;
  end
  task automatic result(input logic [11:0] v);
    adc_result <= v;
  endtask
  // Low span in cycles chosen per conversion kind; call just after an edge
  task automatic pulse(input int n);
    conv_trigger_pin <= 1'b0;
    repeat (n) @(posedge clk_sys);
    conv_trigger_pin <= 1'b1;
  endtask
endmodule // acs_host_model
`default_nettype wire

// >>> verification/acs_sequencer_sva.sv
`default_nettype none
module acs_sequencer_sva (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic busy,
  input wire logic adc_power,
  input wire logic adc_sample,
  input wire logic irq
);
  logic wr_q;
  logic rd_q;
  logic [11:0] a_q;
  logic [4:0] ctrl_q;
  logic [13:0] bcnt;
  wire ctrl_wr = wr_q && a_q == 12'h000;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      a_q <= 12'h000;
      ctrl_q <= 5'h00;
      bcnt <= 14'h0000;
    end else begin
      if (hready) begin
        wr_q <= hsel && htrans[1] && hwrite;
        rd_q <= hsel && htrans[1] && !hwrite;
        a_q <= haddr[11:0];
      end
      if (ctrl_wr) begin
        ctrl_q <= hwdata[4:0];
      end
      bcnt <= busy ? bcnt + 14'h0001 : 14'h0000;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus not zero-wait OKAY");
  busy_min_a: assert property ($rose(busy) |=> busy [*8])
    else $error("busy too short");
  busy_max_a: assert property (bcnt < 14'h1f40)
    else $error("busy too long");
  power_down_a: assert property ($fell(busy) && ctrl_q[1:0] == 2'b00 && !ctrl_q[3]
    |-> ##[0:2] !adc_power) else $error("power kept after scan");
  leave_idle_a: assert property (ctrl_wr && ctrl_q[1:0] != 2'b00 && !busy
    && hwdata[1:0] != ctrl_q[1:0] |-> ##[1:3] !adc_power) else $error("no power down");
  leave_busy_a: assert property (ctrl_wr && hwdata[1:0] != ctrl_q[1:0] && busy
    |=> busy) else $error("scan cut short");
  rsvd_idle_a: assert property (ctrl_q[1:0] == 2'b10 |-> !$rose(busy))
    else $error("scan in reserved mode");
  one_chan_a: assert property ($fell(busy) && ctrl_q[1:0] == 2'b11
    |-> !busy [*3]) else $error("restart without trigger");
  irq_clear_a: assert property (rd_q && a_q == 12'h00c && !busy |-> ##[1:3] !irq)
    else $error("irq not cleared");
  sample_power_a: assert property (adc_sample |-> adc_power)
    else $error("track without power");
endmodule // acs_sequencer_sva
bind acs_sequencer acs_sequencer_sva u_acs_sequencer_sva (.clk_sys(clk_sys), .rst_n(rst_n),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .busy(busy),
  .adc_power(adc_power), .adc_sample(adc_sample), .irq(irq));
`default_nettype wire

// >>> verification/acs_sequencer_tb_top.sv
`include "acs_regs.vh"
`default_nettype none
module acs_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rst_n, hsel, hwrite, ext_ref_sel;
  logic [31:0] haddr, hwdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  wire [31:0] hrdata;
  wire hreadyout, hresp, busy, adc_power, adc_sample, irq, trig;
  wire [11:0] adc_result;
  int error_cnt, cmp_count, n;
  acs_sequencer u_acs_sequencer (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .conv_trigger_pin(trig), .ext_ref_sel(ext_ref_sel), .adc_result(adc_result),
    .busy(busy), .adc_power(adc_power), .adc_sample(adc_sample), .irq(irq));
  acs_host_model u_acs_host_model (.clk_sys(clk_sys), .conv_trigger_pin(trig),
    .adc_result(adc_result));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {20'h00000, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wb(input logic lv, input int lim);
    n = 0;
    while (busy !== lv && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
    chk("busy", {31'h0, lv}, {31'h0, busy});
  endtask
  // Busy span measured between detected edges, so a few cycles of slack
  task automatic conv(input int pn, input int lo, input int hi);
    u_acs_host_model.pulse(pn);
    wb(1'b1, 20);
    wb(1'b0, 9000);
    chk("busy span", 32'h1, {31'h0, n >= lo && n <= hi});
  endtask
  task automatic cnt(input logic [4:0] e);
    bus(1'b0, `ACS_OFF_STAT, 32'h0);
    chk("fifo count", {27'h0, e}, {27'h0, rd[9:5]});
  endtask
  task automatic idle(input int k);
    repeat (k) @(posedge clk_sys);
    chk("idle", 32'h0, {31'h0, busy});
  endtask
  task automatic rst();
    rst_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #1000000;
    error_cnt++;
    summarize();
  end
  initial begin
    {hsel, hwrite, htrans, hsize} = 7'h02;
    {haddr, hwdata} = 64'h0;
    rst_n = 1'b0;
    ext_ref_sel = 1'b1;
    rst();
    bus(1'b0, `ACS_OFF_CTRL, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    bus(1'b0, 12'h3fc, 32'h0);
    chk("unmapped", 32'h0, rd);
    bus(1'b1, `ACS_OFF_MASK, 32'h1);
    bus(1'b1, `ACS_OFF_CTRL, 32'h4);
    bus(1'b1, `ACS_OFF_CHAN, 32'h4);
    wb(1'b1, 20);
    wb(1'b0, 9000);
    repeat (2) @(posedge clk_sys);
    chk("irq", 32'h1, {31'h0, irq});
    bus(1'b0, `ACS_OFF_FIFO, 32'h0);
    chk("fifo word", 32'h25a3, rd);
    bus(1'b0, `ACS_OFF_IRQ, 32'h0);
    chk("irq status", 32'h1, rd);
    bus(1'b1, `ACS_OFF_MASK, 32'h0);
    bus(1'b1, `ACS_OFF_CTRL, 32'h5);
    bus(1'b1, `ACS_OFF_CHAN, 32'hc);
    idle(30);
    u_acs_host_model.result(12'h3c7);
    u_acs_host_model.pulse(1);
    wb(1'b1, 20);
    wb(1'b0, 9000);
    cnt(5'h02);
    bus(1'b0, `ACS_OFF_FIFO, 32'h0);
    chk("fifo word 01", 32'h23c7, rd);
    chk("irq masked", 32'h0, {31'h0, irq});
    bus(1'b1, `ACS_OFF_MASK, 32'h1);
    repeat (2) @(posedge clk_sys);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    bus(1'b0, `ACS_OFF_IRQ, 32'h0);
    bus(1'b1, `ACS_OFF_CTRL, 32'h15);
    bus(1'b1, `ACS_OFF_CHAN, 32'h4);
    bus(1'b1, `ACS_OFF_CTRL, 32'h4);
    repeat (4) @(posedge clk_sys);
    chk("power down", 32'h0, {31'h0, adc_power});
    u_acs_host_model.pulse(1);
    idle(30);
    bus(1'b1, `ACS_OFF_CHAN, 32'h1c);
    wb(1'b1, 20);
    bus(1'b1, `ACS_OFF_CTRL, 32'h5);
    wb(1'b0, 9000);
    cnt(5'h03);
    bus(1'b1, `ACS_OFF_CHAN, 32'hc);
    u_acs_host_model.pulse(1);
    wb(1'b1, 20);
    bus(1'b1, `ACS_OFF_CTRL, 32'h4);
    wb(1'b0, 9000);
    cnt(5'h05);
    rst();
    bus(1'b1, `ACS_OFF_CTRL, 32'h7);
    bus(1'b1, `ACS_OFF_CHAN, 32'h1);
    conv(1, 3190, 3215);
    bus(1'b1, `ACS_OFF_CHAN, 32'h1);
    conv(1, 1195, 1215);
    ext_ref_sel <= 1'b0;
    rst();
    bus(1'b1, `ACS_OFF_CTRL, 32'h7);
    bus(1'b1, `ACS_OFF_CHAN, 32'hc);
    u_acs_host_model.pulse(60);
    idle(30);
    conv(2000, 135, 155);
    cnt(5'h01);
    conv(60, 218, 240);
    ext_ref_sel <= 1'b1;
    bus(1'b1, `ACS_OFF_CHAN, 32'hc);
    u_acs_host_model.pulse(20);
    idle(30);
    u_acs_host_model.pulse(60);
    wb(1'b1, 20);
    u_acs_host_model.pulse(60);
    wb(1'b0, 9000);
    idle(100);
    conv(60, 135, 155);
    bus(1'b1, `ACS_OFF_CHAN, 32'hc);
    conv(60, 135, 155);
    chk("powered wait", 32'h1, {31'h0, adc_power});
    bus(1'b1, `ACS_OFF_CTRL, 32'h1c);
    idle(4);
    chk("exit power", 32'h0, {31'h0, adc_power});
    bus(1'b1, `ACS_OFF_CHAN, 32'h4);
    repeat (800) @(posedge clk_sys);
    bus(1'b0, `ACS_OFF_STAT, 32'h0);
    chk("continuous", 32'h1, {31'h0, rd[9:5] >= 5'h02});
    bus(1'b1, `ACS_OFF_CHAN, 32'h0);
    bus(1'b1, `ACS_OFF_CTRL, 32'h4);
    wb(1'b0, 9000);
    bus(1'b1, `ACS_OFF_CTRL, 32'h5);
    bus(1'b1, `ACS_OFF_CTRL, 32'h14);
    bus(1'b1, `ACS_OFF_CHAN, 32'h4);
    wb(1'b1, 20);
    wb(1'b0, 9000);
    cnt(5'h01);
    summarize();
  end
endmodule // acs_sequencer_tb_top
`default_nettype wire
